//--- rtl/lspc_pkg.sv
// package for the load switch protection controller
package lspc_pkg;
  localparam int LSPC_NSW = 4;
  localparam int LSPC_CFGW = 3;
  // switch configuration codes
  localparam logic [2:0] CFG_OFF = 3'h0;
  localparam logic [2:0] CFG_ON = 3'h1;
  localparam logic [2:0] CFG_TMR1 = 3'h2;
  localparam logic [2:0] CFG_TMR2 = 3'h3;
  localparam logic [2:0] CFG_PWM1 = 3'h4;
  localparam logic [2:0] CFG_PWM2 = 3'h5;
  // register byte addresses (word aligned)
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h4;
  localparam logic [3:0] ADDR_PROT = 4'h8;
  localparam logic [3:0] ADDR_STAT = 4'hC;
  // second bank: mask register at byte 0x10 uses bit 4 of the address
  localparam logic [4:0] ADDR_MASK = 5'h10;
  // status bit positions
  localparam int ST_OC0 = 0;
  localparam int ST_OV = 4;
  localparam int ST_UV = 5;
  localparam int STW = 6;
  // protection control bit positions
  localparam int PR_OVDIS = 0;
  localparam int PR_UVDIS = 1;
  localparam int PR_REC = 2;
  // chip operating modes
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_STOP = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_RESTART = 3'b011,
    MODE_FAILSAFE = 3'b100
  } lspc_mode_t;
  // overcurrent filter time, tSD max
  localparam int OC_FILT_NS = 20000;
  localparam int CLK_NS = 100;
  localparam int OC_FILT_CYC = OC_FILT_NS / CLK_NS;
endpackage

//--- rtl/lspc_oc_if.sv
// interface between controller and overcurrent filters
`timescale 1ns/1ps
interface lspc_oc_if;
  logic ocRaw;
  logic swOn;
  logic trip;
  modport ctrl (output ocRaw, output swOn, input trip);
  modport filt (input ocRaw, input swOn, output trip);
endinterface

//--- rtl/lspc_oc_filter.sv
// overcurrent persistence filter for one switch
`timescale 1ns/1ps
module lspc_oc_filter
  import lspc_pkg::*;
#(
  parameter int FILT_CYC = OC_FILT_CYC
)(
  input wire logic mclk,
  input wire logic resetn,
  lspc_oc_if.filt oc
);
  typedef struct packed {
    logic [15:0] cnt;
    logic trip;
  } lspc_flt_t;
  lspc_flt_t st_r;
  lspc_flt_t st_nxt;
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.trip = 1'b0;
    if (!(oc.ocRaw && oc.swOn))
      st_nxt.cnt = 16'h0000;
    else if (st_r.cnt >= 16'(FILT_CYC))
      st_nxt.trip = 1'b1;
    else
      st_nxt.cnt = st_r.cnt + 16'h0001;
  end
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign oc.trip = st_r.trip;
  // filter holds off early trip
  noEarly_trip_a: assert property (@(posedge mclk) disable iff (!resetn)
    st_r.trip |-> $past(oc.ocRaw, 2))
    else $error("overcurrent trip without persistent fault");
endmodule // lspc_oc_filter

//--- rtl/lspc_top.sv
// load switch control and supply protection with register slave
// What this block does
// - each switch driven by direct, timer or PWM
// - low-power modes keep config, ignore config and protection writes
// - restart or fail-safe forces all outputs off
// - overvoltage turns switches off unless disabled
// - switches return after overvoltage if recovery set
// - undervoltage turns switches off unless disabled
// - switches return after undervoltage if recovery set
// - automatic return of switches on at the fault only when recovery bit is one
// - no recovery: switches on at the fault stay off, config cleared
// - supply faults flag only their two flags
// - persistent overcurrent past filter time trips switch
// - overcurrent sets flag, config cleared to off
// - overcurrent flags stay until host clears
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module lspc_top
  import lspc_pkg::*;
#(
  parameter int NSW = LSPC_NSW,
  parameter int FILT_CYC = OC_FILT_CYC
)(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [4:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic [2:0] chipMode,
  input wire logic supplyOvervoltage,
  input wire logic supplyUndervoltage,
  input wire logic [NSW-1:0] switchOvercurrent,
  input wire logic timer1Out,
  input wire logic timer2Out,
  input wire logic pwm1Out,
  input wire logic pwm2Out,
  output logic [NSW-1:0] loadSwitchOutput,
  output logic irq
);
  typedef struct packed {
    logic [NSW*LSPC_CFGW-1:0] cfg;
    logic [2:0] prot;
    logic [STW-1:0] stat;
    logic [STW-1:0] mask;
    logic [NSW-1:0] drive;
    logic [31:0] rdata;
    logic ack;
  } lspc_state_t;
  lspc_state_t st_r;
  lspc_state_t st_nxt;
  logic [NSW-1:0] trip;
  lspc_mode_t mode;
  assign mode = lspc_mode_t'(chipMode);

  // source selection for one switch
  function automatic logic srcLevel(input logic [2:0] code, input logic t1, input logic t2,
                                    input logic p1, input logic p2);
    unique case (code)
      CFG_ON: srcLevel = 1'b1;
      CFG_TMR1: srcLevel = t1;
      CFG_TMR2: srcLevel = t2;
      CFG_PWM1: srcLevel = p1;
      CFG_PWM2: srcLevel = p2;
      default: srcLevel = 1'b0;
    endcase
  endfunction

  genvar g;
  generate
    for (g = 0; g < NSW; g++)
    begin : gOc
      lspc_oc_if ocIf ();
      assign ocIf.ocRaw = switchOvercurrent[g];
      assign ocIf.swOn = st_r.drive[g];
      assign trip[g] = ocIf.trip;
      lspc_oc_filter #(.FILT_CYC(FILT_CYC)) uFilt (
        .mclk(mclk),
        .resetn(resetn),
        .oc(ocIf)
      );
    end
  endgenerate

  logic req;
  logic inNormal;
  logic ovOff;
  logic uvOff;
  logic supplyOff;
  logic supplyOffD_r;
  logic [31:0] wmask;
  assign req = (avsRead || avsWrite) && !st_r.ack;
  assign inNormal = (mode == MODE_NORMAL);
  assign ovOff = supplyOvervoltage && !st_r.prot[PR_OVDIS];
  assign uvOff = supplyUndervoltage && !st_r.prot[PR_UVDIS];
  assign supplyOff = ovOff || uvOff;
  always_comb
  begin
    for (int b = 0; b < 4; b++)
      wmask[b*8 +: 8] = {8{avsByteEnable[b]}};
  end

  always_comb
  begin
    logic [31:0] wv;
    logic [STW-1:0] setv;
    wv = avsWriteData & wmask;
    setv = '0;
    st_nxt = st_r;
    st_nxt.ack = req;
    // register writes; clears happen before sets so events win
    if (req && avsWrite)
    begin
      unique case (avsAddress)
        {1'b0, ADDR_CTRL_A}:
          if (inNormal)
            st_nxt.cfg[5:0] = (st_r.cfg[5:0] & ~wmask[5:0]) | wv[5:0];
        {1'b0, ADDR_CTRL_B}:
          if (inNormal)
            st_nxt.cfg[11:6] = (st_r.cfg[11:6] & ~wmask[5:0]) | wv[5:0];
        {1'b0, ADDR_PROT}:
          if (inNormal)
            st_nxt.prot = (st_r.prot & ~wmask[2:0]) | wv[2:0];
        {1'b0, ADDR_STAT}: st_nxt.stat = st_r.stat & ~wv[STW-1:0];
        ADDR_MASK: st_nxt.mask = (st_r.mask & ~wmask[STW-1:0]) | wv[STW-1:0];
        default: ;
      endcase
    end
    // supply faults flag only their bits
    setv[ST_OV] = supplyOvervoltage;
    setv[ST_UV] = supplyUndervoltage;
    for (int i = 0; i < NSW; i++)
    begin
      if (trip[i])
      begin
        setv[ST_OC0+i] = 1'b1;
        st_nxt.cfg[i*3 +: 3] = CFG_OFF;
      end
    end
    // no recovery clears config of switches on at the fault
    if (supplyOff && !st_r.prot[PR_REC])
    begin
      for (int i = 0; i < NSW; i++)
        if (st_r.drive[i])
          st_nxt.cfg[i*3 +: 3] = CFG_OFF;
    end
    st_nxt.stat = st_nxt.stat | setv;
    for (int i = 0; i < NSW; i++)
      st_nxt.drive[i] = srcLevel(st_nxt.cfg[i*3 +: 3], timer1Out, timer2Out, pwm1Out, pwm2Out);
    // forced off in restart or fail-safe
    if (mode == MODE_RESTART || mode == MODE_FAILSAFE || supplyOff)
      st_nxt.drive = '0;
    st_nxt.rdata = '0;
    if (req && avsRead)
    begin
      unique case (avsAddress)
        {1'b0, ADDR_CTRL_A}: st_nxt.rdata[5:0] = st_r.cfg[5:0];
        {1'b0, ADDR_CTRL_B}: st_nxt.rdata[5:0] = st_r.cfg[11:6];
        {1'b0, ADDR_PROT}: st_nxt.rdata[2:0] = st_r.prot;
        {1'b0, ADDR_STAT}: st_nxt.rdata[STW-1:0] = st_r.stat;
        ADDR_MASK: st_nxt.rdata[STW-1:0] = st_r.mask;
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '0;
      supplyOffD_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      supplyOffD_r <= supplyOff;
    end
  end

  // one wait cycle per access keeps decode registered
  assign avsWaitRequest = (avsRead || avsWrite) && !st_r.ack;
  assign avsReadData = st_r.rdata;
  assign loadSwitchOutput = st_r.drive;
  assign irq = |(st_r.stat & st_r.mask);

  forcedOff_mode_a: assert property (@(posedge mclk) disable iff (!resetn)
    (mode == MODE_RESTART || mode == MODE_FAILSAFE) |=> (loadSwitchOutput == '0))
    else $error("outputs on in restart or fail-safe");
  ovShut_off_a: assert property (@(posedge mclk) disable iff (!resetn)
    (supplyOvervoltage && !st_r.prot[PR_OVDIS]) |=> (loadSwitchOutput == '0))
    else $error("output on during overvoltage");
  uvShut_off_a: assert property (@(posedge mclk) disable iff (!resetn)
    (supplyUndervoltage && !st_r.prot[PR_UVDIS]) |=> (loadSwitchOutput == '0))
    else $error("output on during undervoltage");
  lockCfg_low_a: assert property (@(posedge mclk) disable iff (!resetn)
    (req && avsWrite && !inNormal && avsAddress == {1'b0, ADDR_CTRL_A} && trip == '0
     && !supplyOff) |=> $stable(st_r.cfg[5:0]))
    else $error("config changed outside normal mode");
  noRec_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    (supplyOff && !st_r.prot[PR_REC] && st_r.drive[0]) |=> (st_r.cfg[2:0] == CFG_OFF))
    else $error("config kept without recovery");
  ocCfg_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    trip[0] |=> (st_r.cfg[2:0] == CFG_OFF && st_r.stat[ST_OC0]))
    else $error("overcurrent trip did not clear config");
  flagSticky_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    (st_r.stat[ST_OC0] && !(req && avsWrite && avsAddress == {1'b0, ADDR_STAT}))
    |=> st_r.stat[ST_OC0])
    else $error("overcurrent flag dropped without clear");
  setWins_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    supplyOvervoltage |=> st_r.stat[ST_OV])
    else $error("overvoltage flag lost on clear");
  supplyOnly_flags_a: assert property (@(posedge mclk) disable iff (!resetn)
    (trip == '0 && !st_r.stat[ST_OC0] && supplyOvervoltage) |=> !st_r.stat[ST_OC0])
    else $error("supply fault set another flag");
  recover_on_a: assert property (@(posedge mclk) disable iff (!resetn)
    (supplyOffD_r && !supplyOff && inNormal && trip == '0 && st_r.prot[PR_REC]
     && !(req && avsWrite) && st_r.cfg[2:0] == CFG_ON) |=> loadSwitchOutput[0])
    else $error("switch did not return after fault");
  cvOcTrip_c: cover property (@(posedge mclk) disable iff (!resetn) trip[0]);
  cvRecover_c: cover property (@(posedge mclk) disable iff (!resetn)
    supplyOffD_r && !supplyOff && loadSwitchOutput[0]);
  cvIrq_c: cover property (@(posedge mclk) disable iff (!resetn) $rose(irq));
endmodule // lspc_top

//--- testbench/lspc_load_model.sv
// load model that can short a switch on request
`timescale 1ns/1ps
module lspc_load_model (
  input wire logic [3:0] drive,
  input wire logic [3:0] shortReq,
  output logic [3:0] overcurrent
);
  // current flows only while the switch drives the load
  assign overcurrent = drive & shortReq;
endmodule // lspc_load_model

//--- testbench/test_load_switch_protect_ctrl.sv
// self-checking bench for the load switch controller
`timescale 1ns/1ps
module test_load_switch_protect_ctrl;
  import lspc_pkg::*;
  localparam logic [4:0] A_CA = {1'h0, ADDR_CTRL_A};
  localparam logic [4:0] A_CB = {1'h0, ADDR_CTRL_B};
  localparam logic [4:0] A_PR = {1'h0, ADDR_PROT};
  localparam logic [4:0] A_ST = {1'h0, ADDR_STAT};
  localparam logic [4:0] A_MK = ADDR_MASK;
  logic mclk = 1'h0, resetn = 1'h0, avsRead = 1'h0, avsWrite = 1'h0;
  logic [4:0] avsAddress = 5'h0;
  logic [31:0] avsWriteData = 32'h0, avsReadData;
  logic avsWaitRequest, irq, ov = 1'h0, uv = 1'h0;
  logic [2:0] chipMode = 3'h0;
  logic [3:0] src = 4'h0, shortReq = 4'h0, ocLine, sw;
  logic [31:0] expQ[$];
  logic [31:0] seed = 32'h9EA7706B;
  int failures = 0, checksDone = 0;
  initial forever #50 mclk = ~mclk;
  lspc_top #(.FILT_CYC(5)) u_lspc_top (.mclk(mclk), .resetn(resetn), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(4'hF), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .chipMode(chipMode), .supplyOvervoltage(ov), .supplyUndervoltage(uv),
    .switchOvercurrent(ocLine), .timer1Out(src[0]), .timer2Out(src[1]), .pwm1Out(src[2]),
    .pwm2Out(src[3]), .loadSwitchOutput(sw), .irq(irq));
  lspc_load_model u_lspc_load_model (.drive(sw), .shortReq(shortReq), .overcurrent(ocLine));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // read data stands in the cycle before the completing edge
  always @(negedge mclk)
    if (avsRead && avsWaitRequest === 1'h0)
      check("readdata", avsReadData, expQ.pop_front());
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do
    begin
      @(negedge mclk);
      n++;
      if (n > 20)
      begin
        failures++;
        close_out();
      end
    end while (avsWaitRequest !== 1'h0);
    @(posedge mclk);
    avsWrite <= 1'h0;
    avsRead <= 1'h0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'h0, a, 32'h0);
  endtask
  task automatic settle(input int n, input logic [3:0] eSw);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
    check("switches", {28'h0, sw}, {28'h0, eSw});
  endtask
  function automatic logic swExp(input logic [2:0] c, input logic [3:0] s);
    case (c)
      CFG_ON: return 1'h1;
      CFG_TMR1: return s[0];
      CFG_TMR2: return s[1];
      CFG_PWM1: return s[2];
      CFG_PWM2: return s[3];
      default: return 1'h0;
    endcase
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  initial
  begin
    logic [11:0] codes;
    logic [3:0] e;
    int pr[5] = '{4, 1, 0, 2, 4};
    logic [3:0] dur[5] = '{4'h0, 4'hF, 4'h0, 4'hF, 4'h0};
    logic [3:0] aft[5] = '{4'hF, 4'hF, 4'h0, 4'hF, 4'hF};
    repeat (5) @(posedge mclk);
    resetn <= 1'h1;
    settle(0, 4'h0);
    rd(A_ST, 32'h0);
    // unmapped place reads zero
    rd(5'h14, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      codes = seed[11:0];
      codes[2:0] = 3'(i);
      for (int k = 0; k < 4; k++) e[k] = swExp(codes[3*k +: 3], seed[15:12]);
      @(posedge mclk);
      src <= seed[15:12];
      wr(A_CA, {26'h0, codes[5:0]});
      wr(A_CB, {26'h0, codes[11:6]});
      settle(1, e);
    end
    $display("test sources done");
    wr(A_CA, 32'h9);
    wr(A_CB, 32'h9);
    for (int m = 1; m < 5; m++)
    begin
      @(posedge mclk);
      chipMode <= 3'(m);
      wr(A_CA, 32'h0);
      if (m < 3) rd(A_CA, 32'h9);
      settle(1, (m < 3) ? 4'hF : 4'h0);
    end
    $display("test modes done");
    for (int c = 0; c < 5; c++)
    begin
      @(posedge mclk);
      chipMode <= MODE_NORMAL;
      wr(A_PR, pr[c]);
      wr(A_CA, 32'h9);
      wr(A_CB, 32'h9);
      ov <= (c < 2);
      uv <= (c > 1);
      settle(2, dur[c]);
      rd(A_ST, (c > 1) ? 32'h20 : 32'h10);
      @(posedge mclk);
      ov <= 1'h0;
      uv <= 1'h0;
      settle(2, aft[c]);
      rd(A_CA, aft[c][0] ? 32'h9 : 32'h0);
      wr(A_ST, 32'h30);
      rd(A_ST, 32'h0);
    end
    $display("test supply done");
    wr(A_PR, 32'h0);
    wr(A_MK, 32'h1);
    @(posedge mclk);
    shortReq <= 4'h1;
    settle(12, 4'hE);
    check("irq", {31'h0, irq}, 32'h1);
    rd(A_ST, 32'h1);
    rd(A_CA, 32'h8);
    @(posedge mclk);
    shortReq <= 4'h0;
    rd(A_ST, 32'h1);
    wr(A_ST, 32'h1);
    rd(A_ST, 32'h0);
    wr(A_CA, 32'h9);
    settle(1, 4'hF);
    check("irq", {31'h0, irq}, 32'h0);
    $display("test overcurrent done");
    close_out();
  end
endmodule // test_load_switch_protect_ctrl
